// ===== rtl/reoreg_top.sv
/*
  Rail override register bank: two host registers that force rails on and set
  register-driven output levels. Assumes the serial interface decoder hands in
  one-cycle read/write strobes on clk, and that kill bits and power-good
  chains arrive from the companion logic on the same clock.
*/
`timescale 1ns/10ps
`include "reoreg_cfg.svh"
// Notes on behaviour
// - first register at a0, eight rail force bits
// - second register at a1, levels and four forces
// - override clear: pin or power-good controls rail
// - override set: rail on unless kill clear
// - shared bit targets switch or LDO strap
// - termination force bit obeys termination kill
// - level bit drives register-controlled output pin
// - output four is open-drain only
// - outputs one to three open-drain or push-pull
// - tree-driven output ignores level, defaults zero
// - kill bit low turns rail off
module reoreg_top #(
  parameter logic [`REO_DATA_W-1:0] RESET_FIRST = `REO_RESET_FIRST,
  parameter logic [`REO_DATA_W-1:0] RESET_SECOND = `REO_RESET_SECOND
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire reoreg_pkg::reo_req_t req,
  output logic [`REO_DATA_W-1:0] rdata,
  output logic rvalid,
  input wire reoreg_pkg::reo_slot_t slot_sel,
  input wire logic [`REO_NUM_RAILS-1:0] kill_n,
  input wire logic [`REO_NUM_RAILS-1:0] ctl_pin_en,
  input wire logic [`REO_NUM_RAILS-1:0] pg_chain_en,
  input wire logic [`REO_NUM_GPO-1:0] gpo_reg_ctrl,
  input wire logic [`REO_NUM_GPO-1:0] gpo_push_pull,
  input wire logic [`REO_NUM_GPO-1:0] gpo_pg_tree,
  output logic [`REO_NUM_RAILS-1:0] rail_en,
  output reoreg_pkg::reo_gpo_t gpo
);
  // Rail index map: 0..5 step-down 1..6, 6 switch a, 7 LDO b, 8 LDO c,
  // 9 switch b, 10 switch c, 11 LDO a, 12 termination.
  localparam int R_LDOC = 8;
  localparam int R_SWB = 9;
  localparam int R_SWC = 10;
  localparam int R_LDOA = 11;
  localparam int R_TERM = 12;

  logic [`REO_DATA_W-1:0] first_r;
  logic [`REO_DATA_W-1:0] first_nxt;
  logic [`REO_DATA_W-1:0] second_r;
  logic [`REO_DATA_W-1:0] second_nxt;
  logic [`REO_DATA_W-1:0] rdata_r;
  logic [`REO_DATA_W-1:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [`REO_NUM_RAILS-1:0] force_vec;
  logic [`REO_NUM_GPO-1:0] level_eff;

  function automatic logic hit(input logic [`REO_ADDR_W-1:0] a,
                               input logic [`REO_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  always_comb begin
    first_nxt = first_r;
    second_nxt = second_r;
    if (req.wr && hit(req.addr, `REO_OFF_FIRST)) begin
      first_nxt = req.wdata;
    end
    if (req.wr && hit(req.addr, `REO_OFF_SECOND)) begin
      second_nxt = req.wdata;
    end
  end

  // Unmapped reads answer zero so the serial side always has a byte to shift.
  always_comb begin
    rvalid_nxt = req.rd;
    rdata_nxt = rdata_r;
    if (req.rd) begin
      if (hit(req.addr, `REO_OFF_FIRST)) begin
        rdata_nxt = first_r;
      end else if (hit(req.addr, `REO_OFF_SECOND)) begin
        rdata_nxt = second_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      first_r <= RESET_FIRST;
      second_r <= RESET_SECOND;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      first_r <= first_nxt;
      second_r <= second_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign rdata = rdata_r;
  assign rvalid = rvalid_r;

  // The shared bit only reaches the rail picked by the strap.
  always_comb begin
    force_vec = '0;
    force_vec[`REO_NUM_FIRST-1:0] = first_r;
    force_vec[R_LDOC] = second_r[`REO_LDOC_BIT];
    force_vec[R_SWB] = second_r[`REO_SWB_BIT];
    force_vec[R_SWC] = second_r[`REO_SHARED_BIT] &&
                       (slot_sel == reoreg_pkg::REO_SLOT_SWITCH);
    force_vec[R_LDOA] = second_r[`REO_SHARED_BIT] &&
                        (slot_sel == reoreg_pkg::REO_SLOT_LDO);
    force_vec[R_TERM] = second_r[`REO_TERM_BIT];
  end

  genvar g;
  generate
    for (g = 0; g < `REO_NUM_RAILS; g++) begin : g_rail
      reoreg_rail_gate u_gate (
        .clk(clk),
        .reset_n(reset_n),
        .force_on(force_vec[g]),
        .keep_n(kill_n[g]),
        .pin_en(ctl_pin_en[g]),
        .pg_en(pg_chain_en[g]),
        .rail_en(rail_en[g])
      );
    end
  endgenerate

  assign level_eff = second_r[`REO_GPO_LSB +: `REO_NUM_GPO];

  reoreg_gpo_drv #(
    .N(`REO_NUM_GPO)
  ) u_gpo (
    .clk(clk),
    .reset_n(reset_n),
    .level(level_eff),
    .reg_ctrl(gpo_reg_ctrl),
    .push_pull(gpo_push_pull),
    .pg_tree(gpo_pg_tree),
    .gpo(gpo)
  );
endmodule

// ===== rtl/reoreg_cfg.svh
/*
  Register offsets, field positions, reset values and widths for the rail
  override register bank. Assumes inclusion by bare name from the design files.
*/
`ifndef REOREG_CFG_SVH
`define REOREG_CFG_SVH
`define REO_ADDR_W 8
`define REO_DATA_W 8
`define REO_OFF_FIRST 8'ha0
`define REO_OFF_SECOND 8'ha1
`define REO_RESET_FIRST 8'h00
`define REO_RESET_SECOND 8'h00
`define REO_NUM_FIRST 8
`define REO_NUM_FORCE2 4
`define REO_NUM_GPO 4
`define REO_GPO_LSB 4
`define REO_TERM_BIT 3
`define REO_SHARED_BIT 2
`define REO_SWB_BIT 1
`define REO_LDOC_BIT 0
`define REO_NUM_RAILS 13
`define REO_OPEN_DRAIN_ONLY 3
`endif

// ===== rtl/reoreg_pkg.sv
/*
  Types shared by the rail override register bank.
  Assumes the configuration header supplies the widths.
*/
`include "reoreg_cfg.svh"
package reoreg_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`REO_ADDR_W-1:0] addr;
    logic [`REO_DATA_W-1:0] wdata;
  } reo_req_t;
  typedef struct packed {
    logic [`REO_NUM_GPO-1:0] out;
    logic [`REO_NUM_GPO-1:0] oe_n;
  } reo_gpo_t;
  typedef enum logic [0:0] {
    REO_SLOT_SWITCH,
    REO_SLOT_LDO
  } reo_slot_t;
endpackage

// ===== rtl/reoreg_rail_gate.sv
/*
  Enable arbitration for one rail: kill, then force-on, then pin or power-good.
  Assumes all inputs are on clk and already synchronised.
*/
`timescale 1ns/10ps
module reoreg_rail_gate (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic force_on,
  input wire logic keep_n,
  input wire logic pin_en,
  input wire logic pg_en,
  output logic rail_en
);
  logic en_r;
  logic en_nxt;

  always_comb begin
    if (!keep_n) begin
      en_nxt = 1'b0;
    end else if (force_on) begin
      en_nxt = 1'b1;
    end else begin
      en_nxt = pin_en | pg_en;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      en_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
    end
  end

  assign rail_en = en_r;
endmodule

// ===== rtl/reoreg_gpo_drv.sv
/*
  Output stage for the four general-purpose outputs, register or power-good
  driven, open-drain or push-pull. Assumes straps are static after reset.
*/
`timescale 1ns/10ps
`include "reoreg_cfg.svh"
module reoreg_gpo_drv #(
  parameter int N = `REO_NUM_GPO
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [N-1:0] level,
  input wire logic [N-1:0] reg_ctrl,
  input wire logic [N-1:0] push_pull,
  input wire logic [N-1:0] pg_tree,
  output reoreg_pkg::reo_gpo_t gpo
);
  reoreg_pkg::reo_gpo_t gpo_r;
  reoreg_pkg::reo_gpo_t gpo_nxt;

  // The level field is fixed at four bits, so no other count can be served.
  if (N != `REO_NUM_GPO) begin : g_bad_count
    $error("gpo count must match the register field");
  end

  always_comb begin
    gpo_nxt = '0;
    for (int i = 0; i < N; i++) begin
      logic v;
      logic pp;
      v = reg_ctrl[i] ? level[i] : pg_tree[i];
      pp = push_pull[i] & (i != `REO_OPEN_DRAIN_ONLY);
      gpo_nxt.out[i] = pp ? v : 1'b0;
      gpo_nxt.oe_n[i] = pp ? 1'b0 : v;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gpo_r <= '{out: '0, oe_n: '1};
    end else begin
      gpo_r <= gpo_nxt;
    end
  end

  assign gpo = gpo_r;
endmodule

// ===== tb/reoreg_chk.sv
/* Port checker for reoreg_top.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
module reoreg_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire reoreg_pkg::reo_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic [12:0] kill_n,
  input wire logic [12:0] ctl_pin_en,
  input wire logic [12:0] pg_chain_en,
  input wire logic [3:0] gpo_reg_ctrl,
  input wire logic [3:0] gpo_push_pull,
  input wire logic [12:0] rail_en,
  input wire reoreg_pkg::reo_gpo_t gpo
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  kill_wins_a: assert property (1 |=> (rail_en & ~$past(kill_n)) == 13'h0000)
    else $error("rail on with kill low");
  pin_on_a: assert property (
    1 |=> (~rail_en & $past(kill_n & (ctl_pin_en | pg_chain_en))) == 13'h0000)
    else $error("pin enable ignored");
  force_one_a: assert property (
    req.wr && req.addr == 8'ha0 && req.wdata[0] ##1 kill_n[0] |=> rail_en[0])
    else $error("force bit ignored");
  force_term_a: assert property (
    req.wr && req.addr == 8'ha1 && req.wdata[3] ##1 kill_n[12] |=> rail_en[12])
    else $error("termination force ignored");
  rd_answer_a: assert property (1 |=> rvalid == $past(req.rd))
    else $error("read answer late");
  rd_hold_a: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved");
  od_four_a: assert property (!gpo.oe_n[3] |-> !gpo.out[3])
    else $error("output four drives high");
  pp_drive_a: assert property (
    1 |=> (gpo.oe_n & $past(gpo_reg_ctrl & gpo_push_pull) & 4'h7) == 4'h0)
    else $error("push-pull output released");
  cover property (rvalid);
  cover property (rail_en[12]);
  cover property (!gpo.oe_n[0] && gpo.out[0]);
endmodule
bind reoreg_top reoreg_chk i_reoreg_chk (.clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata),
  .rvalid(rvalid), .kill_n(kill_n), .ctl_pin_en(ctl_pin_en), .pg_chain_en(pg_chain_en),
  .gpo_reg_ctrl(gpo_reg_ctrl), .gpo_push_pull(gpo_push_pull), .rail_en(rail_en), .gpo(gpo));

// ===== tb/reoreg_host.sv
/* Host model: one-cycle strobes launched on the falling edge.
   Assumes a read is answered within four cycles. */
`timescale 1ns/10ps
module reoreg_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output reoreg_pkg::reo_req_t req
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    d = 'x;
    @(negedge clk);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    req.rd = 1'b0;
    // A missing answer leaves unknown data so the caller's compare fails.
    for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge clk);
    if (rvalid === 1'b1) d = rdata;
  endtask
endmodule

// ===== tb/reoreg_top_bench.sv
/* Self-checking bench for reoreg_top.
   Assumes both registers reset to 00. */
`timescale 1ns/10ps
module reoreg_top_bench;
  logic clk = 0;
  logic reset_n = 0;
  reoreg_pkg::reo_slot_t slot_sel = reoreg_pkg::REO_SLOT_SWITCH;
  logic [12:0] kill_n = '1, ctl_pin_en = '0, pg_chain_en = '0, rail_en;
  logic [3:0] gpo_reg_ctrl = 4'hf, gpo_push_pull = 4'h7, gpo_pg_tree = 4'h0;
  logic [7:0] rdata, d;
  logic rvalid;
  reoreg_pkg::reo_req_t req;
  reoreg_pkg::reo_gpo_t gpo;
  int error_cnt = 0, compares = 0;
  initial forever #25 clk = ~clk;
  reoreg_top i_reoreg_top (.clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata),
    .rvalid(rvalid), .slot_sel(slot_sel), .kill_n(kill_n), .ctl_pin_en(ctl_pin_en),
    .pg_chain_en(pg_chain_en), .gpo_reg_ctrl(gpo_reg_ctrl), .gpo_push_pull(gpo_push_pull),
    .gpo_pg_tree(gpo_pg_tree), .rail_en(rail_en), .gpo(gpo));
  reoreg_host i_reoreg_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
  task chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task settle;
    repeat (2) @(negedge clk);
  endtask
  task finish_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task reg_access;
    i_reoreg_host.rd(8'ha0, d); chk(d, 8'h00);
    i_reoreg_host.rd(8'ha1, d); chk(d, 8'h00);
    i_reoreg_host.wr(8'ha0, 8'h5a);
    i_reoreg_host.wr(8'ha1, 8'ha5);
    i_reoreg_host.wr(8'h9f, 8'hff);
    i_reoreg_host.rd(8'ha0, d); chk(d, 8'h5a);
    i_reoreg_host.rd(8'ha1, d); chk(d, 8'ha5);
    i_reoreg_host.rd(8'ha2, d); chk(d, 8'h00);
  endtask
  task force_on;
    i_reoreg_host.wr(8'ha0, 8'hff);
    i_reoreg_host.wr(8'ha1, 8'h0f);
    settle; chk(rail_en, 13'h17ff);
    slot_sel = reoreg_pkg::REO_SLOT_LDO;
    settle; chk(rail_en, 13'h1bff);
    kill_n = 13'h0ffe;
    settle; chk(rail_en, 13'h0bfe);
    kill_n = '1;
  endtask
  task pin_ctrl;
    i_reoreg_host.wr(8'ha0, 8'h00);
    i_reoreg_host.wr(8'ha1, 8'h00);
    ctl_pin_en = 13'h0f0f;
    pg_chain_en = 13'h1010;
    settle; chk(rail_en, 13'h1f1f);
    ctl_pin_en = '0;
    pg_chain_en = '0;
    settle; chk(rail_en, 13'h0000);
  endtask
  task gpo_levels;
    // Output four stays open-drain, so a high level only releases it.
    i_reoreg_host.wr(8'ha1, 8'hf0);
    settle; chk(gpo, 8'h78);
    i_reoreg_host.wr(8'ha1, 8'h00);
    settle; chk(gpo, 8'h00);
    // Tree-driven outputs must follow the tree, not the level bits.
    gpo_reg_ctrl = 4'h0;
    gpo_pg_tree = 4'h5;
    i_reoreg_host.wr(8'ha1, 8'hf0);
    settle; chk(gpo, 8'h50);
    i_reoreg_host.rd(8'ha1, d); chk(d, 8'hf0);
    gpo_reg_ctrl = 4'hf;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1;
    reg_access;
    force_on;
    pin_ctrl;
    gpo_levels;
    finish_test;
  end
endmodule
